// [design/ucfrc_defs.svh]
`ifndef UCFRC_DEFS_SVH
`define UCFRC_DEFS_SVH
`define UCFRC_ADDR_W 4
`define UCFRC_OFS_CTRL 4'h0
`define UCFRC_BIT_IDLE 31
`define UCFRC_SEL_HI 10
`define UCFRC_SEL_LO 6
`define UCFRC_BIT_TXF 5
`define UCFRC_BIT_RXF 4
`define UCFRC_BIT_FRM 2
`define UCFRC_FLUSH_CLKS 4'h8
`define UCFRC_FRM_CLKS 4'h2
`define UCFRC_SEL_ALL 5'h10
`define UCFRC_NFIFO 16
`define UCFRC_RESP_OKAY 2'h0
`define UCFRC_RESP_SLVERR 2'h2
`endif

// [design/ucfrc_pkg.sv]
package ucfrc_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN} ucfrc_act_type;
   typedef struct packed {
      ucfrc_act_type st;
      logic [3:0] cnt;
   } ucfrc_tmr_type;
endpackage : ucfrc_pkg

// [design/ucfrc_if.sv]
`timescale 1ns/100ps
interface ucfrc_if;
   logic start;
   logic [3:0] len;
   logic busy;
   logic done;
   modport ctrl (output start, output len, input busy, input done);
   modport tmr (input start, input len, output busy, output done);
endinterface : ucfrc_if

// [design/ucfrc_timer.sv]
`timescale 1ns/100ps
// Counts a request for the number of clocks given on len, and raises done in the last of them.
module ucfrc_timer (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Request port.
   ucfrc_if.tmr bus
);
   ucfrc_pkg::ucfrc_tmr_type s_q;
   ucfrc_pkg::ucfrc_tmr_type s_d;

   // Busy while running; done on the last count.
   assign bus.busy = (s_q.st == ucfrc_pkg::ST_RUN);
   assign bus.done = (s_q.st == ucfrc_pkg::ST_RUN) && (s_q.cnt == 4'h1);

   // Next state.
   always_comb begin
      s_d = s_q;
      unique case (s_q.st)
         ucfrc_pkg::ST_IDLE: begin
            if (bus.start) begin
               s_d.st = ucfrc_pkg::ST_RUN;
               s_d.cnt = bus.len;
            end
         end
         ucfrc_pkg::ST_RUN: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == 4'h1) begin
               s_d.st = ucfrc_pkg::ST_IDLE;
            end
         end
         default: s_d.st = ucfrc_pkg::ST_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '{st: ucfrc_pkg::ST_IDLE, cnt: 4'h0};
      end else begin
         s_q <= s_d;
      end
   end
endmodule : ucfrc_timer

// [design/ucfrc_top.sv]
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "ucfrc_defs.svh"
// Reset and flush control register with an AXI4-Lite slave port.
// The block holds one register word at offset zero and answers every other offset with an
// error response, read data zero, and no effect on the register.
// Software starts a flush or a frame counter clear by writing 1 to a request bit; a small
// timer then holds the matching strobe towards the core for a fixed number of clocks and
// clears the request bit when it runs out, so software can poll the bit for completion.
// Writing 0 to a request bit, or writing 1 to one that is already set, does nothing.
// The selector field is frozen while a transmit flush is pending, so a careless write cannot
// move a flush that is already under way onto another FIFO.
// The idle flag is the core's bus master idle input, registered once.
module ucfrc_top (
   // Clock and reset.
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // AXI4-Lite write address and data.
   input wire logic [`UCFRC_ADDR_W-1:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   // AXI4-Lite write response.
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   // AXI4-Lite read.
   input wire logic [`UCFRC_ADDR_W-1:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   // Core side.
   input wire logic I_HOST_MODE,
   input wire logic I_MASTER_IDLE,
   output logic [`UCFRC_NFIFO-1:0] O_TX_FLUSH,
   output logic O_TX_FLUSH_PERIODIC,
   output logic O_RX_FLUSH,
   output logic O_FRAME_CLEAR
);
   // All state of the block outside the timers: the bus slave, the register fields and the core strobes.
   // Write address and data are parked separately because the master may offer them in
   // either order; the write fires only once both are in hand.
   typedef struct packed {
      logic aw_got;
      logic [`UCFRC_ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [4:0] tx_queue_select;
      logic tx_queue_flush_req;
      logic rx_queue_flush_req;
      logic frame_counter_clear_req;
      logic [`UCFRC_NFIFO-1:0] tx_flush;
      logic tx_flush_per;
      logic rx_flush;
      logic frame_clear;
      logic bus_master_quiet;
   } ucfrc_state_type;

   // Registered state, its next value and the write decode.
   ucfrc_state_type s_q;
   ucfrc_state_type s_d;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] rd_word;
   logic [`UCFRC_NFIFO-1:0] sel_vec;

   // Request ports of the three timers.
   ucfrc_if tx_if ();
   ucfrc_if rx_if ();
   ucfrc_if fr_if ();

   // One timer per request: transmit flush, receive flush and frame counter clear.
   // They run independently, so a receive flush may overlap a transmit flush.
   ucfrc_timer u_tx (.i_clk(I_CLK), .i_arst_n(I_ARST_N), .bus(tx_if.tmr));
   ucfrc_timer u_rx (.i_clk(I_CLK), .i_arst_n(I_ARST_N), .bus(rx_if.tmr));
   ucfrc_timer u_fr (.i_clk(I_CLK), .i_arst_n(I_ARST_N), .bus(fr_if.tmr));

   // Bus handshakes: each channel is taken once and held until the response.
   // A channel that has been taken drops its ready until the response has been accepted,
   // which limits the slave to one write and one read under way at a time.
   // The read answer is registered, so read data stand still while the response waits.
   assign O_AWREADY = !s_q.aw_got && !s_q.bvalid;
   assign O_WREADY = !s_q.w_got && !s_q.bvalid;
   assign O_ARREADY = !s_q.rvalid;
   assign O_BVALID = s_q.bvalid;
   assign O_BRESP = s_q.bresp;
   assign O_RVALID = s_q.rvalid;
   assign O_RDATA = s_q.rdata;
   assign O_RRESP = s_q.rresp;
   // A write fires one clock after both halves are parked; only offset zero hits the register.
   assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
   assign wr_hit = wr_fire && (s_q.aw_addr == `UCFRC_OFS_CTRL);

   // Per-FIFO decode of the selector; value 16 selects all of them.
   // The decode ignores the mode: in host mode only bits 0 and 1 reach a real FIFO, and
   // selector values above 16 select nothing at all.
   genvar gi;
   generate
      for (gi = 0; gi < `UCFRC_NFIFO; gi++) begin : g_sel
         assign sel_vec[gi] = (s_q.tx_queue_select == `UCFRC_SEL_ALL) ||
            (s_q.tx_queue_select == 5'(gi));
      end
   endgenerate

   // Read view; reserved bits stay zero.
   // The request bits read back from the register, not from the timers, so a bit reads 1
   // from the write that sets it until the timer that serves it has finished.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_word[`UCFRC_BIT_IDLE] = s_q.bus_master_quiet;
      rd_word[`UCFRC_SEL_HI:`UCFRC_SEL_LO] = s_q.tx_queue_select;
      rd_word[`UCFRC_BIT_TXF] = s_q.tx_queue_flush_req;
      rd_word[`UCFRC_BIT_RXF] = s_q.rx_queue_flush_req;
      rd_word[`UCFRC_BIT_FRM] = s_q.frame_counter_clear_req;
   end

   // Timer starts on the write that sets a request bit.
   // A start is refused while the request is still pending, so a second write of 1 cannot
   // restart a timer in mid-count and stretch the strobe.
   // Only byte lane 0 carries the request bits.
   assign tx_if.start = wr_hit && s_q.w_strb[0] && s_q.w_data[`UCFRC_BIT_TXF]
      && !s_q.tx_queue_flush_req;
   assign tx_if.len = `UCFRC_FLUSH_CLKS;
   assign rx_if.start = wr_hit && s_q.w_strb[0] && s_q.w_data[`UCFRC_BIT_RXF]
      && !s_q.rx_queue_flush_req;
   assign rx_if.len = `UCFRC_FLUSH_CLKS;
   assign fr_if.start = wr_hit && s_q.w_strb[0] && s_q.w_data[`UCFRC_BIT_FRM]
      && !s_q.frame_counter_clear_req;
   assign fr_if.len = `UCFRC_FRM_CLKS;

   // Next state of bus slave and register.
   // A request set by a write wins over a clear from its timer in the same cycle; the timer
   // cannot be done then, since a new start is only taken while no request is pending.
   always_comb begin
      s_d = s_q;
      if (I_AWVALID && O_AWREADY) begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
         s_d.w_got = 1'b1;
         s_d.w_data = I_WDATA;
         s_d.w_strb = I_WSTRB;
      end
      if (wr_fire) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = wr_hit ? `UCFRC_RESP_OKAY : `UCFRC_RESP_SLVERR;
         // Lane 1 holds the upper three selector bits and lane 0 the lower two.
         if (wr_hit && s_q.w_strb[1] && !s_q.tx_queue_flush_req) begin
            s_d.tx_queue_select[4:2] = s_q.w_data[`UCFRC_SEL_HI:`UCFRC_SEL_LO+2];
         end
         if (wr_hit && s_q.w_strb[0] && !s_q.tx_queue_flush_req) begin
            s_d.tx_queue_select[1:0] = s_q.w_data[`UCFRC_SEL_LO+1:`UCFRC_SEL_LO];
         end
      end else if (s_q.bvalid && I_BREADY) begin
         s_d.bvalid = 1'b0;
      end
      if (I_ARVALID && O_ARREADY) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = (I_ARADDR == `UCFRC_OFS_CTRL) ? rd_word : 32'h0000_0000;
         s_d.rresp = (I_ARADDR == `UCFRC_OFS_CTRL) ? `UCFRC_RESP_OKAY : `UCFRC_RESP_SLVERR;
      end else if (s_q.rvalid && I_RREADY) begin
         s_d.rvalid = 1'b0;
      end
      // Request bits stand from the write until the timer is done.
      // Bits clear only on a timer's done or on reset; software has no way to abort a request.
      if (tx_if.start) begin
         s_d.tx_queue_flush_req = 1'b1;
      end else if (tx_if.done) begin
         s_d.tx_queue_flush_req = 1'b0;
      end
      if (rx_if.start) begin
         s_d.rx_queue_flush_req = 1'b1;
      end else if (rx_if.done) begin
         s_d.rx_queue_flush_req = 1'b0;
      end
      if (fr_if.start) begin
         s_d.frame_counter_clear_req = 1'b1;
      end else if (fr_if.done) begin
         s_d.frame_counter_clear_req = 1'b0;
      end
      // Flush strobes to the core, held while the timers run.
      // The periodic strobe follows FIFO 1 in host mode, which an all-FIFO flush includes.
      s_d.tx_flush = tx_if.busy ? sel_vec : '0;
      s_d.tx_flush_per = tx_if.busy && I_HOST_MODE && sel_vec[1];
      s_d.rx_flush = rx_if.busy;
      s_d.frame_clear = fr_if.busy;
      s_d.bus_master_quiet = I_MASTER_IDLE;
   end

   // State register.
   // The idle flag leaves reset at 1, as the core's bus master is quiet while in reset.
   // Every other field leaves reset at zero, with all three readies high.
   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         s_q <= '0;
         s_q.bus_master_quiet <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Core-side outputs come from flip-flops.
   // The strobes lag the timers by one clock, so each strobe stands exactly as many clocks as
   // its timer counts and never glitches between two edges.
   assign O_TX_FLUSH = s_q.tx_flush;
   assign O_TX_FLUSH_PERIODIC = s_q.tx_flush_per;
   assign O_RX_FLUSH = s_q.rx_flush;
   assign O_FRAME_CLEAR = s_q.frame_clear;
endmodule : ucfrc_top

// [verification/ucfrc_chk.sv]
`timescale 1ns/100ps
`include "ucfrc_defs.svh"
// Checks flush strobes and register reads at the ports of the control block.
module ucfrc_chk (
   // Clock and reset.
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   // Write channels.
   input wire logic [`UCFRC_ADDR_W-1:0] I_AWADDR,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_AWVALID,
   input wire logic O_AWREADY,
   input wire logic I_WVALID,
   input wire logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   // Read channel.
   input wire logic [31:0] O_RDATA,
   input wire logic [1:0] O_RRESP,
   input wire logic O_RVALID,
   // Core side.
   input wire logic I_MASTER_IDLE,
   input wire logic [`UCFRC_NFIFO-1:0] O_TX_FLUSH,
   input wire logic O_RX_FLUSH,
   input wire logic O_FRAME_CLEAR
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   logic go;
   // A write to the mapped word with both channels taken at one edge.
   assign go = I_AWVALID && O_AWREADY && I_WVALID && O_WREADY && I_WSTRB[0]
      && I_AWADDR == `UCFRC_OFS_CTRL;
   // A strobe that stands eight cycles and then drops.
   sequence s_eight(x);
      x[*8] ##1 !x;
   endsequence
   tx_len_a: assert property ($rose(|O_TX_FLUSH) |-> s_eight(|O_TX_FLUSH))
      else $error("tx flush length");
   rx_len_a: assert property ($rose(O_RX_FLUSH) |-> s_eight(O_RX_FLUSH))
      else $error("rx flush length");
   tx_go_a: assert property (go && I_WDATA[5] && !(|O_TX_FLUSH) |-> ##[1:3] |O_TX_FLUSH)
      else $error("tx flush not started");
   frm_go_a: assert property (go && I_WDATA[2] |-> ##[1:3] O_FRAME_CLEAR)
      else $error("frame clear not started");
   frm_end_a: assert property ($rose(O_FRAME_CLEAR) |-> ##[1:4] !O_FRAME_CLEAR)
      else $error("frame clear stuck");
   tx_set_a: assert property (|O_TX_FLUSH |-> $onehot(O_TX_FLUSH) || &O_TX_FLUSH)
      else $error("tx flush set wrong");
   resv_a: assert property (O_RVALID |-> O_RDATA[30:11] == '0 && !O_RDATA[3])
      else $error("reserved bits set");
   idle_a: assert property ($rose(O_RVALID) && O_RRESP == `UCFRC_RESP_OKAY
      && $past(I_MASTER_IDLE, 2) == $past(I_MASTER_IDLE) && $past(I_MASTER_IDLE, 3)
      == $past(I_MASTER_IDLE) |-> O_RDATA[31] == $past(I_MASTER_IDLE)) else $error("idle bit");
endmodule : ucfrc_chk
bind ucfrc_top ucfrc_chk chk (.*);

// [verification/ucfrc_tb.sv]
`timescale 1ns/100ps
`include "ucfrc_defs.svh"
// Random and corner register traffic against the flush control block.
module usb_core_fifo_flush_reset_control_test;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, host = 0, idle = 1;
   logic [3:0] awa = 4'h0, ara = 4'h0, wst = 4'hF;
   logic [31:0] wd = 32'h0, rdat, got, w;
   logic awr, wrr, bv, arr, rv, tper, rxf, frm;
   logic [1:0] br, rr, resp;
   logic [15:0] txf, lf = 16'hB8D5;
   logic [4:0] sel;
   int fails = 0, samples_checked = 0;
   // Free-running clock.
   always #5 clk = ~clk;
   // Device under test.
   ucfrc_top dut (.I_CLK(clk), .I_ARST_N(rst_n), .I_AWADDR(awa), .I_AWVALID(awv),
      .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(wst), .I_WVALID(wv), .O_WREADY(wrr),
      .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bre), .I_ARADDR(ara), .I_ARVALID(arv),
      .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rre),
      .I_HOST_MODE(host), .I_MASTER_IDLE(idle), .O_TX_FLUSH(txf),
      .O_TX_FLUSH_PERIODIC(tper), .O_RX_FLUSH(rxf), .O_FRAME_CLEAR(frm));
   // Counts a comparison and reports a mismatch.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Next value of the stimulus shift register.
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Flush strobes expected for a selector value.
   function automatic logic [15:0] exp_tx(input logic [4:0] s);
      return (s == `UCFRC_SEL_ALL) ? 16'hFFFF : 16'h0001 << s;
   endfunction : exp_tx
   // Write one word; each channel is released once it is taken.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic ta, tw, ok;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(negedge clk);
         ta |= awr;
         tw |= wrr;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (!(ta && tw));
      do begin
         @(negedge clk);
         ok = bv;
         resp = br;
         @(posedge clk);
      end while (!ok);
      bre <= 1'b0;
   endtask : wr
   // Read one word into got and resp.
   task automatic rd(input logic [3:0] a);
      logic ok;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(negedge clk);
         ok = arr;
         @(posedge clk);
      end while (!ok);
      arv <= 1'b0;
      do begin
         @(negedge clk);
         ok = rv;
         got = rdat;
         resp = rr;
         @(posedge clk);
      end while (!ok);
      rre <= 1'b0;
   endtask : rd
   // Prints the counts and the verdict, then stops.
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   // Cuts a hang short.
   initial begin
      #100000;
      fails++;
      close_out();
   end
   // Main sequence.
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(`UCFRC_OFS_CTRL);
      check(got, 32'h80000000);
      check(resp, `UCFRC_RESP_OKAY);
      for (int i = 0; i <= 16; i++) begin
         lf = lfsr(lf);
         host <= lf[0];
         sel = 5'(i);
         w = {21'h0, sel, 6'h20};
         // Nothing reads the FIFOs here, and the idle bit is polled before each flush.
         do rd(`UCFRC_OFS_CTRL); while (!got[`UCFRC_BIT_IDLE]);
         wr(`UCFRC_OFS_CTRL, w);
         check(resp, `UCFRC_RESP_OKAY);
         @(negedge clk);
         check(txf, exp_tx(sel));
         check(tper, host && (sel == 5'h01 || sel == `UCFRC_SEL_ALL));
         rd(`UCFRC_OFS_CTRL);
         check(got, w | 32'h80000000);
         repeat (10) @(posedge clk);
         rd(`UCFRC_OFS_CTRL);
         check(got, w ^ 32'h80000020);
      end
      // A reset in mid-flush drops the strobes and clears the register.
      wr(`UCFRC_OFS_CTRL, 32'hE0);
      rst_n <= 1'b0;
      @(negedge clk);
      check(txf, 16'h0000);
      @(posedge clk);
      rst_n <= 1'b1;
      rd(`UCFRC_OFS_CTRL);
      check(got, 32'h80000000);
      wr(`UCFRC_OFS_CTRL, 32'h10);
      @(negedge clk);
      check(rxf, 1'b1);
      rd(`UCFRC_OFS_CTRL);
      check(got, 32'h80000010);
      do rd(`UCFRC_OFS_CTRL); while (got[`UCFRC_BIT_RXF]);
      wr(`UCFRC_OFS_CTRL, 32'h4);
      @(negedge clk);
      check(frm, 1'b1);
      repeat (4) @(posedge clk);
      rd(`UCFRC_OFS_CTRL);
      check(got, 32'h80000000);
      wr(4'h4, 32'h20);
      check(resp, `UCFRC_RESP_SLVERR);
      rd(4'h4);
      check(got, 32'h0);
      check(resp, `UCFRC_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         lf = lfsr(lf);
         idle <= lf[3];
         repeat (2) @(posedge clk);
         rd(`UCFRC_OFS_CTRL);
         check(got, {lf[3], 31'h0});
      end
      close_out();
   end
endmodule : usb_core_fifo_flush_reset_control_test
